// ### src/ext_pin_irq_unit.sv
// Top of the external pin and pin change interrupt unit
//
// Notes on behaviour
// - Group zero fires on enabled toggle 7..0
// - Group one fires on enabled toggle 10..8
// - Group two fires on enabled toggle 17..11
// - Three masks pick pins for groups
// - Pins still fire when driven as outputs
// - Pin change detection needs no I/O clock
// - Edge sensing needs running I/O clock
// - Low level sensing needs no I/O clock
// - Low level must last through wake-up
// - Low gone early: wake without interrupt
// - Level mode requests while pin low
// - Pin one sense field bits 3:2
// - Pin zero sense field bits 1:0
// - Pin sampled before edge detection
// - Mask bit 7 enables pin one
// - Mask bit 6 enables pin zero
// - Mask bit 5 enables group zero
// - Mask bit 4 enables group two
// - Mask bit 3 enables group one
// - Mask bits 2..0 read zero
// - Flag sets on trigger, clears on ack/write-one
// - Pin flag reads clear in level mode
// - Each mask bit gates its pin
`default_nettype none
`include "ext_irq_map.svh"
module ext_pin_irq_unit
   import ext_irq_pkg::*;
#(
   parameter int CHANGE_WIDTH = `CHG_TOTAL_W,
   parameter int SYNC_STAGES = 2
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic ext_irq_pin_zero,
   input wire logic ext_irq_pin_one,
   input wire logic [CHANGE_WIDTH-1:0] change_inputs,
   input wire logic global_irq_en,
   input wire logic io_clk_running,
   input wire logic ext_zero_ack,
   input wire logic ext_one_ack,
   input wire logic change_group_zero_ack,
   input wire logic change_group_one_ack,
   input wire logic change_group_two_ack,
   output logic ext_zero_req,
   output logic ext_one_req,
   output logic change_group_zero_req,
   output logic change_group_one_req,
   output logic change_group_two_req,
   output logic wake_req,
   output logic [3:0] sleep_ctrl
);
   localparam int PIN_W = CHANGE_WIDTH + 2;

   // The group split is fixed, so only the documented width is served
   initial begin
      if (CHANGE_WIDTH != `CHG_TOTAL_W) begin
         $error("CHANGE_WIDTH must equal the fixed group layout");
      end
      if (SYNC_STAGES < 2) begin
         $error("SYNC_STAGES below two is no synchroniser");
      end
   end

   // Set wins over clear, so an event in the clearing cycle survives
   function automatic logic next_flag(input logic flag, input logic set,
                                      input logic clr);
      next_flag = set | (flag & ~clr);
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      hit = (a == b);
   endfunction

   // Registers
   logic [7:0] sense_and_sleep_control;
   logic [7:0] ext_irq_enable_mask;
   logic [`CHG_ZERO_W-1:0] change_mask_zero;
   logic [`CHG_ONE_W-1:0] change_mask_one;
   logic [`CHG_TWO_W-1:0] change_mask_two;
   logic ext_zero_pending;
   logic ext_one_pending;
   logic change_zero_pending;
   logic change_one_pending;
   logic change_two_pending;

   // Pin synchronisers; stage zero is read only by stage one
   logic [PIN_W-1:0] sync_pipe [SYNC_STAGES];
   logic [PIN_W-1:0] pins_sync;
   logic [CHANGE_WIDTH-1:0] change_sync;
   logic [CHANGE_WIDTH-1:0] change_prev;
   logic [CHANGE_WIDTH-1:0] toggled;
   logic group_zero_hit;
   logic group_one_hit;
   logic group_two_hit;

   logic wr_flags;
   logic ext_zero_clr;
   logic ext_one_clr;
   logic chg_zero_clr;
   logic chg_one_clr;
   logic chg_two_clr;
   logic zero_is_level;
   logic one_is_level;
   logic [7:0] flags_view;
   logic [7:0] next_rdata;

   ext_sense_if sense_zero ();
   ext_sense_if sense_one ();

   // Pads are read as levels whatever drives them, so writing a pin that
   // is an output raises the interrupt just the same
   // No reset here: the stages keep following the pads through reset, so
   // a register write at the first edge after release sees no false edge
   always_ff @(posedge core_clk) begin
      sync_pipe[0] <= {ext_irq_pin_one, ext_irq_pin_zero,
                       change_inputs};
      for (int i = 1; i < SYNC_STAGES; i++) begin
         sync_pipe[i] <= sync_pipe[i-1];
      end
   end

   assign pins_sync = sync_pipe[SYNC_STAGES-1];
   assign change_sync = pins_sync[CHANGE_WIDTH-1:0];

   // Pin zero and pin one detectors
   assign sense_zero.mode =
      sense_mode_e'(sense_and_sleep_control[`SENSE0_HI:`SENSE0_LO]);
   assign sense_zero.pin = pins_sync[CHANGE_WIDTH];
   assign sense_zero.clk_run = io_clk_running;
   assign sense_one.mode =
      sense_mode_e'(sense_and_sleep_control[`SENSE1_HI:`SENSE1_LO]);
   assign sense_one.pin = pins_sync[CHANGE_WIDTH+1];
   assign sense_one.clk_run = io_clk_running;

   ext_pin_sense u_sense_zero (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .sense(sense_zero.detector)
   );

   ext_pin_sense u_sense_one (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .sense(sense_one.detector)
   );

   assign zero_is_level = (sense_zero.mode == sense_low);
   assign one_is_level = (sense_one.mode == sense_low);

   // Pin change sampling runs on the always-on clock, not the I/O clock,
   // so a change is seen in every sleep mode
   // Previous sample also runs through reset to match the synchroniser
   always_ff @(posedge core_clk) begin
      change_prev <= change_sync;
   end

   assign toggled = change_sync ^ change_prev;

   // Each mask bit gates exactly its own pin inside the group
   assign group_zero_hit =
      |(toggled[`GRP0_HI:`GRP0_LO] & change_mask_zero);
   assign group_one_hit =
      |(toggled[`GRP1_HI:`GRP1_LO] & change_mask_one);
   assign group_two_hit =
      |(toggled[`GRP2_HI:`GRP2_LO] & change_mask_two);

   // Register writes
   assign wr_flags = wr & hit(addr, `ADDR_IRQ_FLAGS);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sense_and_sleep_control <= `RST_BYTE;
      end else if (wr && hit(addr, `ADDR_SENSE_CTRL)) begin
         sense_and_sleep_control <= wdata;
      end
   end

   // Reserved mask bits are never stored, so they always read zero
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ext_irq_enable_mask <= `RST_BYTE;
      end else if (wr && hit(addr, `ADDR_IRQ_MASK)) begin
         ext_irq_enable_mask <= `ZERO_BYTE;
         ext_irq_enable_mask[`BIT_EXT_ONE] <= wdata[`BIT_EXT_ONE];
         ext_irq_enable_mask[`BIT_EXT_ZERO] <= wdata[`BIT_EXT_ZERO];
         ext_irq_enable_mask[`BIT_CHG_ZERO] <= wdata[`BIT_CHG_ZERO];
         ext_irq_enable_mask[`BIT_CHG_TWO] <= wdata[`BIT_CHG_TWO];
         ext_irq_enable_mask[`BIT_CHG_ONE] <= wdata[`BIT_CHG_ONE];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         change_mask_zero <= '0;
         change_mask_one <= '0;
         change_mask_two <= '0;
      end else if (wr) begin
         if (hit(addr, `ADDR_CHG_MASK_ZERO)) begin
            change_mask_zero <= wdata[`CHG_ZERO_W-1:0];
         end else if (hit(addr, `ADDR_CHG_MASK_ONE)) begin
            change_mask_one <= wdata[`CHG_ONE_W-1:0];
         end else if (hit(addr, `ADDR_CHG_MASK_TWO)) begin
            change_mask_two <= wdata[`CHG_TWO_W-1:0];
         end
      end
   end

   // Flag clears: write one from software, or the core entering the vector
   assign ext_zero_clr = (wr_flags & wdata[`BIT_EXT_ZERO]) | ext_zero_ack;
   assign ext_one_clr = (wr_flags & wdata[`BIT_EXT_ONE]) | ext_one_ack;
   assign chg_zero_clr = (wr_flags & wdata[`BIT_CHG_ZERO]) |
                         change_group_zero_ack;
   assign chg_one_clr = (wr_flags & wdata[`BIT_CHG_ONE]) |
                        change_group_one_ack;
   assign chg_two_clr = (wr_flags & wdata[`BIT_CHG_TWO]) |
                        change_group_two_ack;

   // External pin flags are held clear while their pin is level sensed
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ext_zero_pending <= `RST_BIT;
         ext_one_pending <= `RST_BIT;
      end else begin
         if (zero_is_level) begin
            ext_zero_pending <= 1'b0;
         end else begin
            ext_zero_pending <= next_flag(ext_zero_pending,
                                          sense_zero.trigger,
                                          ext_zero_clr);
         end
         if (one_is_level) begin
            ext_one_pending <= 1'b0;
         end else begin
            ext_one_pending <= next_flag(ext_one_pending,
                                         sense_one.trigger,
                                         ext_one_clr);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         change_zero_pending <= `RST_BIT;
         change_one_pending <= `RST_BIT;
         change_two_pending <= `RST_BIT;
      end else begin
         change_zero_pending <= next_flag(change_zero_pending,
                                          group_zero_hit,
                                          chg_zero_clr);
         change_one_pending <= next_flag(change_one_pending,
                                         group_one_hit,
                                         chg_one_clr);
         change_two_pending <= next_flag(change_two_pending,
                                         group_two_hit,
                                         chg_two_clr);
      end
   end

   // Requests to the core. A level request is the live pin, so a low that
   // goes away before the core wakes leaves no request behind; the pin
   // driver must keep it low through start-up and the current instruction
   always_comb begin
      ext_one_req = 1'b0;
      ext_zero_req = 1'b0;
      if (global_irq_en && ext_irq_enable_mask[`BIT_EXT_ONE]) begin
         if (one_is_level) begin
            ext_one_req = sense_one.level_low;
         end else begin
            ext_one_req = ext_one_pending;
         end
      end
      if (global_irq_en && ext_irq_enable_mask[`BIT_EXT_ZERO]) begin
         if (zero_is_level) begin
            ext_zero_req = sense_zero.level_low;
         end else begin
            ext_zero_req = ext_zero_pending;
         end
      end
   end

   assign change_group_zero_req = global_irq_en &
      ext_irq_enable_mask[`BIT_CHG_ZERO] & change_zero_pending;
   assign change_group_two_req = global_irq_en &
      ext_irq_enable_mask[`BIT_CHG_TWO] & change_two_pending;
   assign change_group_one_req = global_irq_en &
      ext_irq_enable_mask[`BIT_CHG_ONE] & change_one_pending;

   // Wake-up ignores the global flag: a masked-off core still wakes and
   // then simply continues after its sleep instruction
   assign wake_req =
      (ext_irq_enable_mask[`BIT_EXT_ZERO] & sense_zero.level_low) |
      (ext_irq_enable_mask[`BIT_EXT_ONE] & sense_one.level_low) |
      (ext_irq_enable_mask[`BIT_CHG_ZERO] & change_zero_pending) |
      (ext_irq_enable_mask[`BIT_CHG_ONE] & change_one_pending) |
      (ext_irq_enable_mask[`BIT_CHG_TWO] & change_two_pending);

   assign sleep_ctrl = sense_and_sleep_control[`SLEEP_HI:`SLEEP_LO];

   // Read path
   always_comb begin
      flags_view = `ZERO_BYTE;
      flags_view[`BIT_EXT_ONE] = ext_one_pending;
      flags_view[`BIT_EXT_ZERO] = ext_zero_pending;
      flags_view[`BIT_CHG_ZERO] = change_zero_pending;
      flags_view[`BIT_CHG_TWO] = change_two_pending;
      flags_view[`BIT_CHG_ONE] = change_one_pending;
   end

   always_comb begin
      next_rdata = `ZERO_BYTE;
      if (hit(addr, `ADDR_SENSE_CTRL)) begin
         next_rdata = sense_and_sleep_control;
      end else if (hit(addr, `ADDR_IRQ_MASK)) begin
         next_rdata = ext_irq_enable_mask;
      end else if (hit(addr, `ADDR_IRQ_FLAGS)) begin
         next_rdata = flags_view;
      end else if (hit(addr, `ADDR_CHG_MASK_ZERO)) begin
         next_rdata = change_mask_zero;
      end else if (hit(addr, `ADDR_CHG_MASK_ONE)) begin
         next_rdata = {5'h00, change_mask_one};
      end else if (hit(addr, `ADDR_CHG_MASK_TWO)) begin
         next_rdata = {1'h0, change_mask_two};
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata <= `RST_BYTE;
      end else if (rd) begin
         rdata <= next_rdata;
      end else begin
         rdata <= `ZERO_BYTE;
      end
   end
endmodule // ext_pin_irq_unit
`default_nettype wire

// ### src/ext_irq_map.svh
// Register offsets, field positions and reset values of the pin interrupt unit
`ifndef EXT_IRQ_MAP_SVH
`define EXT_IRQ_MAP_SVH

`define ADDR_SENSE_CTRL 8'h35
`define ADDR_CHG_MASK_TWO 8'h05
`define ADDR_CHG_MASK_ONE 8'h30
`define ADDR_CHG_MASK_ZERO 8'h31
`define ADDR_IRQ_MASK 8'h32
`define ADDR_IRQ_FLAGS 8'h33

`define RST_BYTE 8'h00
`define RST_BIT 1'b0
`define ZERO_BYTE 8'h00

`define BIT_EXT_ONE 7
`define BIT_EXT_ZERO 6
`define BIT_CHG_ZERO 5
`define BIT_CHG_TWO 4
`define BIT_CHG_ONE 3

`define SENSE1_HI 3
`define SENSE1_LO 2
`define SENSE0_HI 1
`define SENSE0_LO 0
`define SLEEP_HI 7
`define SLEEP_LO 4

`define GRP0_HI 7
`define GRP0_LO 0
`define GRP1_HI 10
`define GRP1_LO 8
`define GRP2_HI 17
`define GRP2_LO 11

`define CHG_ZERO_W 8
`define CHG_ONE_W 3
`define CHG_TWO_W 7
`define CHG_TOTAL_W 18

`endif

// ### src/ext_irq_pkg.sv
// Types shared by the pin interrupt unit
`default_nettype none
package ext_irq_pkg;
   // Order follows the two-bit sense field encoding
   typedef enum logic [1:0] {
      sense_low,
      sense_any,
      sense_fall,
      sense_rise
   } sense_mode_e;
endpackage
`default_nettype wire

// ### src/ext_sense_if.sv
// Signals between the top and one external pin sense detector
`default_nettype none
interface ext_sense_if;
   import ext_irq_pkg::*;
   sense_mode_e mode;
   logic pin;
   logic clk_run;
   logic trigger;
   logic level_low;
   modport top (output mode, output pin, output clk_run,
                input trigger, input level_low);
   modport detector (input mode, input pin, input clk_run,
                     output trigger, output level_low);
endinterface
`default_nettype wire

// ### src/ext_pin_sense.sv
// Edge, change and low level detector for one synchronised external pin
`default_nettype none
`include "ext_irq_map.svh"
module ext_pin_sense
   import ext_irq_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   ext_sense_if.detector sense
);
   logic prev;
   logic rise;
   logic fall;

   // Previous sample; the pin was synchronised before it got here.
   // It keeps tracking through reset, so release shows no false edge
   always_ff @(posedge core_clk) begin
      prev <= sense.pin;
   end

   assign rise = sense.pin & ~prev;
   assign fall = ~sense.pin & prev;

   // Edges count only while the I/O clock runs
   always_comb begin
      sense.trigger = 1'b0;
      if (sense.clk_run && rst_n) begin
         case (sense.mode)
            sense_any: sense.trigger = rise | fall;
            sense_fall: sense.trigger = fall;
            sense_rise: sense.trigger = rise;
            default: sense.trigger = 1'b0;
         endcase
      end
   end

   // Level needs no I/O clock
   assign sense.level_low = (sense.mode == sense_low) & ~sense.pin;
endmodule // ext_pin_sense
`default_nettype wire

// ### tb/ext_pin_irq_unit_properties.sv
// Port-level checker for the pin interrupt unit, bound to its top
`default_nettype none
`include "ext_irq_map.svh"
module ext_pin_irq_checker (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic ext_irq_pin_zero,
   input wire logic global_irq_en,
   input wire logic change_group_zero_ack,
   input wire logic ext_zero_req,
   input wire logic ext_one_req,
   input wire logic change_group_zero_req,
   input wire logic change_group_one_req,
   input wire logic change_group_two_req
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] en;
   logic [1:0] sense0;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Shadows follow bus writes so the checks need no design internals
   always_ff @(posedge core_clk) begin
      if (!rst_n) en <= 8'h00;
      else if (wr && addr == `ADDR_IRQ_MASK) en <= wdata;
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) sense0 <= 2'b00;
      else if (wr && addr == `ADDR_SENSE_CTRL) sense0 <= wdata[1:0];
   end
   property p_one_gate;
      ext_one_req |-> global_irq_en && en[7];
   endproperty
   a_one_gate: assert property (p_one_gate)
      else $error("pin one request while not enabled");
   property p_zero_gate;
      ext_zero_req |-> global_irq_en && en[6];
   endproperty
   a_zero_gate: assert property (p_zero_gate)
      else $error("pin zero request while not enabled");
   property p_grp0_gate;
      $rose(change_group_zero_req) |-> en[5] && global_irq_en;
   endproperty
   a_grp0_gate: assert property (p_grp0_gate)
      else $error("group zero request while not enabled");
   property p_grp2_gate;
      !(global_irq_en && en[4]) |-> !change_group_two_req;
   endproperty
   a_grp2_gate: assert property (p_grp2_gate)
      else $error("group two request while not enabled");
   property p_grp1_gate;
      change_group_one_req |-> en[3] && global_irq_en;
   endproperty
   a_grp1_gate: assert property (p_grp1_gate)
      else $error("group one request while not enabled");
   property p_level_req;
      (sense0 == 2'b00 && en[6] && global_irq_en && !ext_irq_pin_zero)[*3]
         |-> ext_zero_req;
   endproperty
   a_level_req: assert property (p_level_req)
      else $error("held low level gives no request");
   property p_level_gone;
      (sense0 == 2'b00 && en[6] && ext_irq_pin_zero)[*3] |-> !ext_zero_req;
   endproperty
   a_level_gone: assert property (p_level_gone)
      else $error("request stays after low level left");
   property p_mask_rsvd;
      rd && addr == `ADDR_IRQ_MASK |=> rdata[2:0] == 3'b000;
   endproperty
   a_mask_rsvd: assert property (p_mask_rsvd)
      else $error("reserved enable bits read nonzero");
   property p_level_flag;
      rd && addr == `ADDR_IRQ_FLAGS && sense0 == 2'b00
         && $past(sense0) == 2'b00 |=> !rdata[6];
   endproperty
   a_level_flag: assert property (p_level_flag)
      else $error("pin zero flag set in level mode");
   property p_req_holds;
      change_group_zero_req && !change_group_zero_ack && !wr
         |=> change_group_zero_req || !global_irq_en;
   endproperty
   a_req_holds: assert property (p_req_holds)
      else $error("group zero request dropped without entry");
endmodule // ext_pin_irq_checker
bind ext_pin_irq_unit ext_pin_irq_checker i_ext_pin_irq_checker (
   .core_clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .ext_irq_pin_zero,
   .global_irq_en, .change_group_zero_ack, .ext_zero_req, .ext_one_req,
   .change_group_zero_req, .change_group_one_req, .change_group_two_req);
`default_nettype wire

// ### tb/core_ack_model.sv
// Core side stand-in: enters each requested vector after a set delay
`default_nettype none
module core_ack_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [4:0] req,
   input wire logic [7:0] ack_delay,
   output logic [4:0] ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wait_cnt [5];
   // Count restarts after each entry, so a held level request is
   // entered again as a core would after its routine returns
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 5; i++) begin
         ack[i] <= 1'b0;
         if (!rst_n || !req[i] || ack[i]) begin
            wait_cnt[i] <= 8'h00;
         end else if (wait_cnt[i] == ack_delay) begin
            ack[i] <= 1'b1;
            wait_cnt[i] <= 8'h00;
         end else begin
            wait_cnt[i] <= wait_cnt[i] + 8'h01;
         end
      end
   end
endmodule // core_ack_model
`default_nettype wire

// ### tb/ext_pin_irq_unit_tb.sv
// Self-checking bench for the pin interrupt unit
`default_nettype none
`include "ext_irq_map.svh"
module ext_pin_irq_unit_tb import ext_irq_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, ack_delay = 8'h02;
   logic ext_irq_pin_zero = 1'b1, ext_irq_pin_one = 1'b1, wake_req;
   logic [17:0] change_inputs = 18'h00000;
   logic global_irq_en = 1'b0, io_clk_running = 1'b1;
   logic [4:0] req, ack;
   logic [3:0] sleep_ctrl;
   int mismatches = 0, samples_checked = 0;
   logic [7:0] regs [6] = '{`ADDR_SENSE_CTRL, `ADDR_IRQ_MASK,
      `ADDR_IRQ_FLAGS, `ADDR_CHG_MASK_ZERO, `ADDR_CHG_MASK_ONE,
      `ADDR_CHG_MASK_TWO};
   logic [7:0] back [6] = '{8'hff, 8'hf8, 8'h00, 8'hff, 8'h07, 8'h7f};
   int bit_of [5] = '{6, 7, 5, 3, 4};
   int pin_of [5] = '{0, 0, 3, 9, 15};
   always #5 core_clk = ~core_clk;
   ext_pin_irq_unit i_ext_pin_irq_unit (
      .core_clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
      .ext_irq_pin_zero, .ext_irq_pin_one, .change_inputs,
      .global_irq_en, .io_clk_running,
      .ext_zero_ack(ack[0]), .ext_one_ack(ack[1]),
      .change_group_zero_ack(ack[2]), .change_group_one_ack(ack[3]),
      .change_group_two_ack(ack[4]),
      .ext_zero_req(req[0]), .ext_one_req(req[1]),
      .change_group_zero_req(req[2]), .change_group_one_req(req[3]),
      .change_group_two_req(req[4]), .wake_req, .sleep_ctrl);
   core_ack_model i_core_ack_model (.core_clk, .rst_n, .req, .ack_delay,
      .ack);
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked,
         mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, mismatches);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask
   task automatic wait_req(input int k, input logic lvl);
      int n;
      n = 0;
      while (req[k] !== lvl && n < 20) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check({7'h00, req[k]}, {7'h00, lvl});
      if (n == 20) summarize();
   endtask
   task automatic set_pin(input int p, input logic v);
      if (p == 0) ext_irq_pin_zero <= v;
      else ext_irq_pin_one <= v;
   endtask
   initial begin
      logic [17:0] one_hot, noise;
      int s, e;
      void'($urandom(32'had73d2de));
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (regs[i]) begin
         rd_chk(regs[i], `RST_BYTE);
         wr_reg(regs[i], 8'hff);
         rd_chk(regs[i], back[i]);
      end
      check({4'h0, sleep_ctrl}, 8'h0f);
      wr_reg(8'h40, 8'h5a);
      rd_chk(8'h40, `ZERO_BYTE);
      foreach (regs[i]) wr_reg(regs[i], `ZERO_BYTE);
      end_test("registers");
      // Noise on unmasked pins must not reach any group flag
      for (int i = 0; i < 18; i++) begin
         one_hot = 18'h00001 << i;
         noise = 18'($urandom()) & ~one_hot;
         wr_reg(`ADDR_CHG_MASK_ZERO, one_hot[7:0]);
         wr_reg(`ADDR_CHG_MASK_ONE, {5'h00, one_hot[10:8]});
         wr_reg(`ADDR_CHG_MASK_TWO, {1'b0, one_hot[17:11]});
         @(posedge core_clk);
         change_inputs <= change_inputs ^ one_hot ^ noise;
         repeat (4) @(posedge core_clk);
         s = i < 8 ? 5 : (i < 11 ? 3 : 4);
         rd_chk(`ADDR_IRQ_FLAGS, 8'h01 << s);
         wr_reg(`ADDR_IRQ_FLAGS, 8'h01 << s);
         rd_chk(`ADDR_IRQ_FLAGS, 8'h00);
      end
      foreach (regs[i]) wr_reg(regs[i], `ZERO_BYTE);
      end_test("pin change");
      // Pulses last several clocks; edges are lost with the clock off
      for (int c = 1; c >= 0; c--) begin
         for (int p = 0; p < 2; p++) begin
            for (int m = 1; m < 4; m++) begin
               e = p ? `BIT_EXT_ONE : `BIT_EXT_ZERO;
               io_clk_running <= c[0];
               wr_reg(`ADDR_SENSE_CTRL, 8'(m << (2 * p)));
               for (int v = 0; v < 2; v++) begin
                  @(posedge core_clk);
                  set_pin(p, v[0]);
                  repeat (4) @(posedge core_clk);
                  rd_chk(`ADDR_IRQ_FLAGS, (c == 1 && m != 3 - v) ?
                     8'h01 << e : 8'h00);
                  wr_reg(`ADDR_IRQ_FLAGS, 8'hff);
               end
            end
         end
      end
      end_test("edge sense");
      for (int p = 0; p < 2; p++) begin
         wr_reg(`ADDR_SENSE_CTRL, `ZERO_BYTE);
         global_irq_en <= 1'b0;
         wr_reg(`ADDR_IRQ_MASK, 8'h40 << p);
         set_pin(p, 1'b0);
         repeat (4) @(posedge core_clk);
         #1;
         check({6'h00, wake_req, req[p]}, 8'h02);
         @(posedge core_clk);
         global_irq_en <= 1'b1;
         repeat (8) @(posedge core_clk);
         #1;
         check({6'h00, wake_req, req[p]}, 8'h03);
         rd_chk(`ADDR_IRQ_FLAGS, 8'h00);
         @(posedge core_clk);
         set_pin(p, 1'b1);
         wait_req(p, 1'b0);
      end
      end_test("low level");
      @(posedge core_clk);
      io_clk_running <= 1'b1;
      wr_reg(`ADDR_SENSE_CTRL, 8'h05);
      wr_reg(`ADDR_CHG_MASK_ZERO, 8'hff);
      wr_reg(`ADDR_CHG_MASK_ONE, 8'h07);
      wr_reg(`ADDR_CHG_MASK_TWO, 8'h7f);
      for (int k = 0; k < 5; k++) begin
         wr_reg(`ADDR_IRQ_MASK, 8'h01 << bit_of[k]);
         ack_delay <= 8'($urandom_range(6));
         if (k < 2) set_pin(k, 1'b0);
         else change_inputs[pin_of[k]] <= ~change_inputs[pin_of[k]];
         wait_req(k, 1'b1);
         check({3'h0, req}, 8'h01 << k);
         wait_req(k, 1'b0);
         rd_chk(`ADDR_IRQ_FLAGS, 8'h00);
      end
      end_test("service");
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      // Masks open right after release must not catch a false toggle
      wr_reg(`ADDR_CHG_MASK_ZERO, 8'hff);
      wr_reg(`ADDR_CHG_MASK_TWO, 8'h7f);
      repeat (4) @(posedge core_clk);
      rd_chk(`ADDR_IRQ_FLAGS, `RST_BYTE);
      rd_chk(`ADDR_SENSE_CTRL, `RST_BYTE);
      rd_chk(`ADDR_IRQ_MASK, `RST_BYTE);
      check({3'h0, req}, 8'h00);
      end_test("second reset");
      summarize();
   end
endmodule // ext_pin_irq_unit_tb
`default_nettype wire
